// *** hdl/csr_guard.sv ***
// Purpose: reserved-bit check for control/status writes
// Assumes: caller registers the result
// Notes: purely combinational
`timescale 1ns/1ps
module csr_guard
  import simd_state_pkg::*;
(
  input wire logic load_i,
  input wire logic [31:0] value_i,
  input wire logic [31:0] current_i,
  output logic [31:0] csr_d_o,
  output logic fault_o
);
  // any one outside the supported mask faults; the register keeps its value
  always_comb begin
    fault_o = load_i && ((value_i & ~SUPPORTED_MASK) != 32'h0000_0000);
    csr_d_o = current_i;
    if (load_i && !fault_o) begin
      csr_d_o = value_i;
    end
  end
endmodule : csr_guard

// *** hdl/simd_state_init_save.sv ***
// Purpose: vector state holder with reset init, soft init and image save/restore
// Assumes: image memory on the far side answers word requests
// Notes: soft init aborts a running save or restore and blocks new walks, register and control/status writes
`timescale 1ns/1ps

// How it works
// RULE1: hard reset loads control/status with 1F80H, exceptions 7-12 masked.
// RULE2: hard reset clears sticky flag bits 0 through 5.
// RULE3: hard reset sets rounding bits 13-14 to 00, round to nearest.
// RULE4: hard reset clears flush-to-zero bit 15.
// RULE5: hard reset clears bit 6; here it is reserved and stays zero.
// RULE6: hard reset clears all eight vector registers to zero.
// RULE7: soft init leaves vector and control/status registers unchanged.
// RULE8: save streams vectors and control/status into 512-byte image; restore reloads.
// RULE9: save and restore also carry scalar state and integer-vector registers.
// RULE10: writing one to any reserved control/status bit raises protection fault.
// RULE11: supported-bits mask is reported in image bytes 28 through 31.
// RULE12: a zero mask means default 0000FFBFH; this device reports nonzero.
// RULE13: mask zeros mark reserved bits, ones mark supported features.
// RULE14: software should AND values with the mask before writing.
// RULE15: software saves scalar state before using integer-vector registers.
// RULE16: software empties integer-vector state before returning to scalar work.
// RULE17: vector-only accesses interleave freely with scalar and integer-vector work.
// RULE18: vector data kept in native width, never widened.
// RULE19: a faulting control/status write leaves the register unchanged.
module simd_state_init_save
  import simd_state_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_init_i,
  input wire logic ctl_load_i,
  input wire logic [31:0] ctl_wdata_i,
  input wire logic vec_we_i,
  input wire logic [2:0] vec_idx_i,
  input wire logic [VEC_W-1:0] vec_wdata_i,
  input wire logic [2:0] vec_ridx_i,
  input wire logic scalar_we_i,
  input wire logic [2:0] scalar_idx_i,
  input wire logic [VEC_W-1:0] scalar_wdata_i,
  input wire logic scalar_ctl_we_i,
  input wire logic [31:0] scalar_ctl_i,
  input wire logic save_start_i,
  input wire logic restore_start_i,
  input wire logic img_rd_valid_i,
  input wire logic [31:0] img_rd_data_i,
  output img_port_t img_o,
  output logic [31:0] csr_o,
  output logic [VEC_W-1:0] vec_rdata_o,
  output logic protection_fault_o,
  output logic busy_o,
  output logic op_done_o
);
  logic init_meta_q;
  logic init_q;
  op_state_t state_d;
  op_state_t state_q;
  logic [IMG_AW-1:0] cnt_d;
  logic [IMG_AW-1:0] cnt_q;
  img_port_t img_d;
  img_port_t img_q;
  logic done_d;
  logic done_q;
  logic busy_d;
  logic busy_q;
  logic [31:0] csr_d;
  logic [31:0] csr_q;
  logic [31:0] sctl_d;
  logic [31:0] sctl_q;
  logic fault_d;
  logic fault_q;
  logic [VEC_W-1:0] vrd_d;
  logic [VEC_W-1:0] vrd_q;
  logic first_q;
  logic g_load;
  logic [31:0] g_value;
  logic [31:0] g_csr;
  logic g_fault;
  logic rst_word;
  logic vb_lane_we;
  logic sb_lane_we;
  logic [6:0] v_off;
  logic [6:0] s_off;
  reg_array_t vregs;
  reg_array_t sregs;

  // word of the saved image at a given index
  // RULE11 RULE12 RULE13 nonzero mask word
  function automatic logic [31:0] image_word(input logic [6:0] idx, input logic [31:0] csr,
                                             input logic [31:0] sctl, input reg_array_t sr,
                                             input reg_array_t vr);
    logic [6:0] off;
    off = 7'h00;
    if (idx == W_SCALAR_CTL) begin
      image_word = sctl;
    end else if (idx == W_CSR) begin
      image_word = csr;
    end else if (idx == W_MASK) begin
      image_word = SUPPORTED_MASK;
    end else if (idx >= W_SCALAR_BASE && idx < W_VEC_BASE) begin
      off = idx - W_SCALAR_BASE;
      image_word = sr[off[4:2]][off[1:0]*32 +: 32];
    end else if (idx >= W_VEC_BASE && idx < W_VEC_END) begin
      off = idx - W_VEC_BASE;
      image_word = vr[off[4:2]][off[1:0]*32 +: 32];
    end else begin
      image_word = 32'h0000_0000;
    end
  endfunction : image_word

  // soft-init pin synchroniser
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_meta_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      init_meta_q <= soft_init_i;
      init_q <= init_meta_q;
    end
  end

  // save/restore sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    img_d = '0;
    rst_word = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (init_q) begin
          state_d = ST_IDLE;
        end else if (save_start_i) begin
          state_d = ST_SAVE;
          cnt_d = '0;
        end else if (restore_start_i) begin
          state_d = ST_RESTORE;
          cnt_d = '0;
          img_d.rd = 1'b1;
        end
      end
      ST_SAVE: begin
        // RULE8 stream image out
        img_d.wr = 1'b1;
        img_d.addr = cnt_q;
        img_d.data = image_word(cnt_q, csr_q, sctl_q, sregs, vregs);
        cnt_d = cnt_q + 7'h01;
        if (cnt_q == W_LAST) begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_RESTORE: begin
        img_d.rd = 1'b1;
        img_d.addr = cnt_q;
        if (img_rd_valid_i) begin
          rst_word = 1'b1;
          cnt_d = cnt_q + 7'h01;
          img_d.addr = cnt_d;
          if (cnt_q == W_LAST) begin
            state_d = ST_IDLE;
            img_d.rd = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // RULE7 soft init aborts a walk only
    if (init_q) begin
      state_d = ST_IDLE;
      img_d = '0;
      rst_word = 1'b0;
      done_d = 1'b0;
    end
    // busy follows the next state so the output is a flop
    busy_d = state_d != ST_IDLE;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      img_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      img_q <= img_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // word offsets for restored register lanes
  assign v_off = cnt_q - W_VEC_BASE;
  assign s_off = cnt_q - W_SCALAR_BASE;
  // RULE9 scalar regs restored
  assign sb_lane_we = rst_word && cnt_q >= W_SCALAR_BASE && cnt_q < W_VEC_BASE;
  assign vb_lane_we = rst_word && cnt_q >= W_VEC_BASE && cnt_q < W_VEC_END;

  // RULE17 vector writes take no mode check
  vec_bank u_vec (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .we_i(vec_we_i && state_q == ST_IDLE && !init_q),
    .idx_i(vb_lane_we ? v_off[4:2] : vec_idx_i),
    .data_i(vec_wdata_i),
    .lane_we_i(vb_lane_we),
    .lane_i(v_off[1:0]),
    .lane_data_i(img_rd_data_i),
    .regs_o(vregs)
  );

  vec_bank u_scalar (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .we_i(scalar_we_i && state_q == ST_IDLE && !init_q),
    .idx_i(sb_lane_we ? s_off[4:2] : scalar_idx_i),
    .data_i(scalar_wdata_i),
    .lane_we_i(sb_lane_we),
    .lane_i(s_off[1:0]),
    .lane_data_i(img_rd_data_i),
    .regs_o(sregs)
  );

  // control/status source: restore word or direct load
  always_comb begin
    g_load = 1'b0;
    g_value = ctl_wdata_i;
    if (rst_word && cnt_q == W_CSR) begin
      g_load = 1'b1;
      g_value = img_rd_data_i;
    end else if (ctl_load_i && state_q == ST_IDLE && !init_q) begin
      g_load = 1'b1;
    end
  end

  // RULE10 reserved-bit check
  csr_guard u_guard (
    .load_i(g_load),
    .value_i(g_value),
    .current_i(csr_q),
    .csr_d_o(g_csr),
    .fault_o(g_fault)
  );

  // control/status, scalar control word and read data
  always_comb begin
    // RULE19 guard keeps old value
    csr_d = g_csr;
    fault_d = g_fault;
    sctl_d = sctl_q;
    if (rst_word && cnt_q == W_SCALAR_CTL) begin
      sctl_d = img_rd_data_i;
    end else if (scalar_ctl_we_i && state_q == ST_IDLE && !init_q) begin
      sctl_d = scalar_ctl_i;
    end
    // RULE18 native 128-bit width
    vrd_d = vregs[vec_ridx_i];
  end

  // RULE1 RULE2 RULE3 RULE4 RULE5 reset value
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      csr_q <= CSR_RESET;
      sctl_q <= 32'h0000_0000;
      fault_q <= 1'b0;
      vrd_q <= '0;
      first_q <= 1'b1;
    end else begin
      csr_q <= csr_d;
      sctl_q <= sctl_d;
      fault_q <= fault_d;
      vrd_q <= vrd_d;
      first_q <= 1'b0;
    end
  end

  assign img_o = img_q;
  assign csr_o = csr_q;
  assign vec_rdata_o = vrd_q;
  assign protection_fault_o = fault_q;
  assign busy_o = busy_q;
  assign op_done_o = done_q;

  property p_reset_state;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    first_q |-> csr_q == 32'h0000_1F80 && vregs == '0 && csr_q[DENORM_ZERO_BIT] == 1'b0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state"); // RULE1
  property p_fault_load;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ctl_load_i && state_q == ST_IDLE && !init_q && ctl_wdata_i[DENORM_ZERO_BIT]
      |=> protection_fault_o;
  endproperty
  a_fault_load: assert property (p_fault_load) else $error("no fault on reserved bit"); // RULE10
  property p_fault_keep;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    g_fault |=> csr_q == $past(csr_q) && protection_fault_o;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("faulting write changed csr"); // RULE19
  property p_no_reserved;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (csr_q & ~SUPPORTED_MASK) == 32'h0000_0000;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved csr bit set"); // RULE13
  property p_mask_word;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    img_o.wr && img_o.addr == W_MASK |-> img_o.data == 32'h0000_FFBF;
  endproperty
  a_mask_word: assert property (p_mask_word) else $error("bad mask word"); // RULE11
  property p_save_len;
    @(posedge ref_clk_i) disable iff (!arst_n_i || init_q)
    state_q == ST_IDLE && save_start_i && !init_q |-> ##1 !op_done_o [*8] ##121 op_done_o;
  endproperty
  a_save_len: assert property (p_save_len) else $error("save walk wrong length"); // RULE8
  property p_soft_init;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    init_q && state_q == ST_IDLE |=> $stable(csr_q) && $stable(vregs);
  endproperty
  a_soft_init: assert property (p_soft_init) else $error("soft init changed state"); // RULE7
  property p_scalar_word;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    state_q == ST_SAVE && cnt_q == W_SCALAR_CTL && !init_q |=> img_o.data == $past(sctl_q);
  endproperty
  a_scalar_word: assert property (p_scalar_word) else $error("scalar word not saved"); // RULE9
endmodule : simd_state_init_save

// *** hdl/simd_state_pkg.sv ***
// Purpose: shared constants and types for the vector state holder
// Assumes: one 40 MHz clock, 32-bit state image words
// Notes: image is 512 bytes, streamed as 128 words
package simd_state_pkg;
  localparam int NUM_VEC = 8;
  localparam int VEC_W = 128;
  localparam int CSR_W = 32;
  localparam int IMG_BYTES = 512;
  localparam int IMG_WORDS = IMG_BYTES / 4;
  localparam int IMG_AW = 7;
  localparam int LANES = VEC_W / 32;
  // control/status reset and field positions
  localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
  localparam int FLAG_LO = 0;
  localparam int FLAG_HI = 5;
  localparam int DENORM_ZERO_BIT = 6;
  localparam int XMASK_LO = 7;
  localparam int XMASK_HI = 12;
  localparam int RC_LO = 13;
  localparam int RC_HI = 14;
  localparam int FTZ_BIT = 15;
  // denormal-as-zero mode is not built, so bit 6 is reserved
  localparam logic DENORM_ZERO_SUPPORTED = 1'b0;
  localparam logic [31:0] MASK_DEFAULT = 32'h0000_FFBF;
  localparam logic [31:0] MASK_FULL = 32'h0000_FFFF;
  localparam logic [31:0] SUPPORTED_MASK = DENORM_ZERO_SUPPORTED ? MASK_FULL : MASK_DEFAULT;
  // word indexes inside the image
  localparam logic [6:0] W_SCALAR_CTL = 7'h00;
  localparam logic [6:0] W_CSR = 7'h06;
  localparam logic [6:0] W_MASK = 7'h07;
  localparam logic [6:0] W_SCALAR_BASE = 7'h08;
  localparam logic [6:0] W_VEC_BASE = 7'h28;
  localparam logic [6:0] W_VEC_END = 7'h48;
  localparam logic [6:0] W_LAST = 7'h7F;
  // save walk length in cycles, start to done
  localparam int SAVE_CYCLES = IMG_WORDS + 1;

  typedef logic [NUM_VEC-1:0][VEC_W-1:0] reg_array_t;
  typedef enum {ST_IDLE, ST_SAVE, ST_RESTORE} op_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [IMG_AW-1:0] addr;
    logic [31:0] data;
  } img_port_t;
endpackage : simd_state_pkg

// *** hdl/vec_bank.sv ***
// Purpose: bank of eight 128-bit registers, cleared by hard reset
// Assumes: whole-register or 32-bit lane writes, never both at once
// Notes: used for vector and scalar/integer-vector state
`timescale 1ns/1ps
module vec_bank
  import simd_state_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [2:0] idx_i,
  input wire logic [VEC_W-1:0] data_i,
  input wire logic lane_we_i,
  input wire logic [1:0] lane_i,
  input wire logic [31:0] lane_data_i,
  output reg_array_t regs_o
);
  // unpacked so each generated process owns its own element
  logic [VEC_W-1:0] regs_d [NUM_VEC];
  logic [VEC_W-1:0] regs_q [NUM_VEC];

  for (genvar g = 0; g < NUM_VEC; g++) begin : g_reg
    // next value per register
    always_comb begin
      regs_d[g] = regs_q[g];
      if (we_i && idx_i == 3'(g)) begin
        regs_d[g] = data_i;
      end else if (lane_we_i && idx_i == 3'(g)) begin
        regs_d[g][lane_i*32 +: 32] = lane_data_i;
      end
    end
    // RULE6 cleared on reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        regs_q[g] <= '0;
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // pack the registers for the output
  always_comb begin
    for (int i = 0; i < NUM_VEC; i++) begin
      regs_o[i] = regs_q[i];
    end
  end
endmodule : vec_bank

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the vector state holder
// Assumes: 40 MHz clock, image memory answered by the bench every other cycle
// Notes: expected image built from a bench-side copy of all state
`timescale 1ns/1ps
module tb
  import simd_state_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic soft_init_i = 1'b0, ctl_load_i = 1'b0, vec_we_i = 1'b0, scalar_we_i = 1'b0;
  logic scalar_ctl_we_i = 1'b0, save_start_i = 1'b0, restore_start_i = 1'b0;
  logic img_rd_valid_i = 1'b0;
  logic [31:0] ctl_wdata_i = 32'h0, scalar_ctl_i = 32'h0, img_rd_data_i = 32'h0;
  logic [2:0] vec_idx_i = 3'h0, vec_ridx_i = 3'h0, scalar_idx_i = 3'h0;
  logic [VEC_W-1:0] vec_wdata_i = '0, scalar_wdata_i = '0;
  img_port_t img_o;
  logic [31:0] csr_o;
  logic [VEC_W-1:0] vec_rdata_o;
  logic protection_fault_o, busy_o, op_done_o;
  int mismatches = 0, checks = 0, nf;
  logic [127:0] vexp[8], sexp[8];
  logic [31:0] cexp, sctl_exp, rimg[128];
  logic f;
  logic [31:0] ld_val[5] = '{32'h0000_FFBF, 32'h0000_6A15, 32'h0000_0040, 32'h0001_0000,
                             32'h8000_0000};

  simd_state_init_save dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .soft_init_i(soft_init_i), .ctl_load_i(ctl_load_i), .ctl_wdata_i(ctl_wdata_i),
    .vec_we_i(vec_we_i), .vec_idx_i(vec_idx_i), .vec_wdata_i(vec_wdata_i),
    .vec_ridx_i(vec_ridx_i), .scalar_we_i(scalar_we_i), .scalar_idx_i(scalar_idx_i),
    .scalar_wdata_i(scalar_wdata_i), .scalar_ctl_we_i(scalar_ctl_we_i),
    .scalar_ctl_i(scalar_ctl_i), .save_start_i(save_start_i),
    .restore_start_i(restore_start_i), .img_rd_valid_i(img_rd_valid_i),
    .img_rd_data_i(img_rd_data_i), .img_o(img_o), .csr_o(csr_o), .vec_rdata_o(vec_rdata_o),
    .protection_fault_o(protection_fault_o), .busy_o(busy_o), .op_done_o(op_done_o));

  // free-running clock, 25 ns period
  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // expected image word from the bench copy of the state
  function automatic logic [31:0] img_word(input int w);
    if (w == 0) return sctl_exp;
    if (w == 6) return cexp;
    if (w == 7) return 32'h0000_FFBF;
    if (w >= 8 && w < 40) return sexp[(w-8)/4][((w-8)%4)*32 +: 32];
    if (w >= 40 && w < 72) return vexp[(w-40)/4][((w-40)%4)*32 +: 32];
    return 32'h0;
  endfunction : img_word

  task automatic read_vec(input logic [2:0] i, output logic [127:0] v);
    @(posedge ref_clk_i) vec_ridx_i <= i;
    repeat (2) @(posedge ref_clk_i);
    #1 v = vec_rdata_o;
  endtask : read_vec

  task automatic check_vecs();
    logic [127:0] v;
    for (int i = 0; i < 8; i++) begin
      read_vec(3'(i), v);
      check(v, vexp[i]);
    end
  endtask : check_vecs

  // vector, scalar and scalar-control writes in the same cycle
  task automatic wr_regs(input logic [2:0] i, input logic [127:0] vd, input logic [127:0] sd,
                         input logic [31:0] sc, input bit upd);
    @(posedge ref_clk_i) begin
      vec_we_i <= 1'b1; vec_idx_i <= i; vec_wdata_i <= vd;
      scalar_we_i <= 1'b1; scalar_idx_i <= ~i; scalar_wdata_i <= sd;
      scalar_ctl_we_i <= 1'b1; scalar_ctl_i <= sc;
    end
    @(posedge ref_clk_i) begin
      vec_we_i <= 1'b0; scalar_we_i <= 1'b0; scalar_ctl_we_i <= 1'b0;
    end
    if (upd) begin
      vexp[i] = vd; sexp[~i] = sd; sctl_exp = sc;
    end
  endtask : wr_regs

  task automatic ctl_load(input logic [31:0] v, output logic flt);
    @(posedge ref_clk_i) begin
      ctl_load_i <= 1'b1; ctl_wdata_i <= v;
    end
    @(posedge ref_clk_i) ctl_load_i <= 1'b0;
    #1 flt = protection_fault_o;
    repeat (2) begin
      @(posedge ref_clk_i);
      #1 flt = flt | protection_fault_o;
    end
  endtask : ctl_load

  task automatic save_and_compare();
    logic [31:0] got[128];
    int n;
    n = 0;
    @(posedge ref_clk_i) save_start_i <= 1'b1;
    @(posedge ref_clk_i) save_start_i <= 1'b0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
      if (n == 1) check(busy_o, 1'b1);
      if (img_o.wr === 1'b1) got[img_o.addr] = img_o.data;
    end while (op_done_o !== 1'b1 && n < 400);
    check(n, IMG_WORDS);
    check({op_done_o, busy_o}, 2'b10);
    for (int w = 0; w < 128; w++) check(got[w], img_word(w));
    check(got[8], sexp[0][31:0]);
    check(got[7], 32'h0000_FFBF);
    check(got[7][6], 1'b0);
  endtask : save_and_compare

  // slow image memory: one word every other cycle
  task automatic restore(input logic [31:0] base, input logic [31:0] cw, output int flt_n);
    int n;
    bit done;
    for (int w = 0; w < 128; w++) rimg[w] = base | w;
    rimg[6] = cw;
    rimg[7] = 32'h0;
    n = 0;
    flt_n = 0;
    done = 0;
    @(posedge ref_clk_i) restore_start_i <= 1'b1;
    @(posedge ref_clk_i) restore_start_i <= 1'b0;
    while (!done && n < 600) begin
      @(posedge ref_clk_i);
      n++;
      if (protection_fault_o === 1'b1) flt_n++;
      if (op_done_o === 1'b1) done = 1;
      if (img_o.rd === 1'b1 && img_rd_valid_i !== 1'b1) begin
        img_rd_valid_i <= 1'b1; img_rd_data_i <= rimg[img_o.addr];
      end else img_rd_valid_i <= 1'b0;
    end
    @(posedge ref_clk_i) img_rd_valid_i <= 1'b0;
    if (protection_fault_o === 1'b1) flt_n++;
    check(done, 1'b1);
    sctl_exp = rimg[0];
    if ((cw & ~32'h0000_FFBF) == 32'h0) cexp = cw;
    for (int w = 8; w < 72; w++) begin
      if (w < 40) sexp[(w-8)/4][((w-8)%4)*32 +: 32] = rimg[w];
      else vexp[(w-40)/4][((w-40)%4)*32 +: 32] = rimg[w];
    end
  endtask : restore

  task automatic check_reset();
    #1 check(csr_o, 32'h0000_1F80);
    check(csr_o[12:7], 6'h3F);
    check(csr_o[5:0], 6'h00);
    check(csr_o[14:13], 2'b00);
    check(csr_o[15], 1'b0);
    check(csr_o[6], 1'b0);
    for (int i = 0; i < 8; i++) vexp[i] = '0;
    cexp = 32'h0000_1F80;
    check_vecs();
  endtask : check_reset

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    check_reset();
    for (int i = 0; i < 8; i++)
      wr_regs(3'(i), {32'hA000_0300 | i, 32'hA000_0200 | i, 32'hA000_0100 | i, 32'hA000_0000 | i},
              {32'hB000_0300 | i, 32'hB000_0200 | i, 32'hB000_0100 | i, 32'hB000_0000 | i},
              32'h0000_0370 | i, 1'b1);
    for (int k = 0; k < 5; k++) begin
      ctl_load(ld_val[k], f);
      check(f, (ld_val[k] & ~32'h0000_FFBF) != 32'h0);
      if ((ld_val[k] & ~32'h0000_FFBF) == 32'h0) cexp = ld_val[k];
      check(csr_o, cexp);
    end
    save_and_compare();
    restore(32'h5A00_0000, 32'h0000_A081, nf);
    check(nf, 0);
    check(csr_o, 32'h0000_A081);
    check_vecs();
    save_and_compare();
    restore(32'h3C00_0000, 32'h0000_0040, nf);
    check(nf, 1);
    check(csr_o, 32'h0000_A081);
    save_and_compare();
    @(posedge ref_clk_i) soft_init_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wr_regs(3'h2, '1, '1, 32'h0, 1'b0);
    ctl_load(32'h0000_2000, f);
    check(f, 1'b0);
    @(posedge ref_clk_i) soft_init_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 check(csr_o, cexp);
    check_vecs();
    @(posedge ref_clk_i) arst_n_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    check_reset();
    tally_and_finish();
  end
endmodule : tb
